/* src/sfid_flash_end.sv */
// Flash end: command interpreter for identity, OTP mode, reset and
// write enable latch. Assumes link pins come from another clock domain.
`timescale 1ns/1ps
`include "sfid_regs.svh"
module sfid_flash_end #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] TYPE_ID = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h11 // Arbitrary value
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  sfid_link_if.flash link, // Serial link to host
  input wire logic busy, // Program or erase running
  input wire logic write_done, // Pulse: program, erase or register write done
  input wire logic suspend, // Pulse: program or erase suspended
  output logic write_enable_latch_r, // Write enable latch
  output logic otp_mode_r, // Secured OTP area selected
  output logic soft_reset_r, // Pulse: software reset executed
  output sfid_pkg::sfid_byte_type cmd_byte_r, // Opcode passed on
  output logic cmd_strobe_r // Pulse: cmd_byte_r valid
);
  import sfid_pkg::*;

  logic [2:0] pin_q;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  sfid_dev_state_type st_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_r;
  logic [7:0] op_r;
  logic op_seen_r;
  logic [1:0] pre_cnt_r;
  logic [1:0] seq_r;
  logic [7:0] sh_r;
  logic arm_r;
  logic miso_r;
  logic miso_oe_r;
  logic cs_low;
  logic sclk_up;
  logic sclk_dn;
  logic cs_up;
  logic cs_dn;
  logic byte_done;
  logic [7:0] rx_byte;
  logic frame_ok;
  logic [2:0] out_cnt_r;

  // Last bit of the current output byte
  function automatic logic sh_cnt_last();
    return out_cnt_r == `SFID_BIT_LAST;
  endfunction

  // Pins: {cs_b, sclk, mosi}; upper data lines never enter the block
  sfid_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({link.cs_b, link.sclk, link.mosi}),
    .q(pin_q),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_low = ~pin_q[2];
  assign cs_up = pin_rise[2];
  assign cs_dn = pin_fall[2];
  assign sclk_up = pin_rise[1] & cs_low;
  assign sclk_dn = pin_fall[1] & cs_low;
  assign byte_done = sclk_up && (bit_cnt_r == `SFID_BIT_LAST);
  assign rx_byte = {rx_r[6:0], pin_q[0]};
  // A single-byte frame closed on a byte boundary
  assign frame_ok = cs_up && (st_r == DEV_HOLD) && (bit_cnt_r == `SFID_BIT_FIRST);

  // Byte picked by the current output sequence position
  function automatic logic [7:0] out_sel(input logic [7:0] op, input logic [1:0] seq);
    logic [7:0] b;
    b = DEVICE_ID;
    if (op == `SFID_OP_IDENT) begin
      case (seq)
        2'h0: b = MAKER_ID;
        2'h1: b = TYPE_ID;
        default: b = DEVICE_ID;
      endcase
    end else if (op == `SFID_OP_MKDEV) begin
      b = seq[0] ? DEVICE_ID : MAKER_ID;
    end
    return b;
  endfunction

  // Next sequence position after a whole byte has gone out
  function automatic logic [1:0] seq_step(input logic [7:0] op, input logic [1:0] seq);
    logic [1:0] n;
    n = seq;
    if (op == `SFID_OP_IDENT) begin
      n = (seq == `SFID_IDENT_LAST) ? 2'h0 : seq + 2'h1;
    end else if (op == `SFID_OP_MKDEV) begin
      n = {1'b0, ~seq[0]};
    end
    return n;
  endfunction

  // Input shifter, sampled on rising serial clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_r <= `SFID_BIT_FIRST;
      rx_r <= 8'h00;
    end else if (!cs_low) begin
      bit_cnt_r <= `SFID_BIT_FIRST;
    end else if (sclk_up) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_r <= rx_byte;
    end
  end

  // Command state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= DEV_IDLE;
      op_r <= 8'h00;
      op_seen_r <= 1'b0;
      pre_cnt_r <= 2'h0;
      seq_r <= 2'h0;
    end else if (cs_up) begin
      st_r <= DEV_IDLE;
    end else if (cs_dn) begin
      st_r <= DEV_CMD;
      op_seen_r <= 1'b0;
    end else if (byte_done) begin
      case (st_r)
        DEV_CMD: begin
          op_r <= rx_byte;
          op_seen_r <= 1'b1;
          pre_cnt_r <= 2'h0;
          seq_r <= 2'h0;
          case (rx_byte)
            `SFID_OP_IDENT: st_r <= busy ? DEV_IGNORE : DEV_OUT;
            `SFID_OP_SIG: st_r <= DEV_PRE;
            `SFID_OP_MKDEV: st_r <= DEV_PRE;
            `SFID_OP_WL_SET: st_r <= DEV_HOLD;
            `SFID_OP_WL_CLR: st_r <= DEV_HOLD;
            `SFID_OP_OTP_IN: st_r <= DEV_HOLD;
            `SFID_OP_OTP_OUT: st_r <= DEV_HOLD;
            `SFID_OP_RST_ARM: st_r <= DEV_HOLD;
            `SFID_OP_RST_GO: st_r <= DEV_HOLD;
            default: st_r <= DEV_IGNORE;
          endcase
        end
        DEV_PRE: begin
          pre_cnt_r <= pre_cnt_r + 2'h1;
          if (pre_cnt_r == `SFID_PRE_BYTES_LAST) begin
            st_r <= DEV_OUT;
            if (op_r == `SFID_OP_MKDEV && rx_byte == `SFID_ADDR_DEV_FIRST) begin
              seq_r <= 2'h1;
            end
          end
        end
        // Extra bytes after a single-byte command void it
        DEV_HOLD: st_r <= DEV_IGNORE;
        default: st_r <= st_r;
      endcase
    end else if (st_r == DEV_OUT && sclk_dn && sh_cnt_last()) begin
      seq_r <= seq_step(op_r, seq_r);
    end
  end

  // Output shifter: one bit per falling serial clock, MSB first.
  // Start position, and for identity read also the opcode, land in the same
  // edge that enters DEV_OUT, so the first byte is reloaded until the first fall.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_r <= 8'h00;
      out_cnt_r <= `SFID_BIT_FIRST;
      miso_r <= 1'b1;
      miso_oe_r <= 1'b0;
    end else if (st_r != DEV_OUT || (!miso_oe_r && !sclk_dn)) begin
      sh_r <= out_sel(op_r, seq_r);
      out_cnt_r <= `SFID_BIT_FIRST;
      miso_oe_r <= 1'b0;
    end else if (sclk_dn) begin
      miso_oe_r <= 1'b1;
      miso_r <= sh_r[7];
      out_cnt_r <= out_cnt_r + 3'h1;
      if (sh_cnt_last()) begin
        sh_r <= out_sel(op_r, seq_step(op_r, seq_r));
      end else begin
        sh_r <= {sh_r[6:0], 1'b0};
      end
    end
  end

  // Reset arm flag: any other completed or aborted command disarms
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_r <= 1'b0;
    end else if (cs_up && op_seen_r) begin
      arm_r <= frame_ok && (op_r == `SFID_OP_RST_ARM);
    end
  end

  // Software reset pulse, only straight after an arm frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= frame_ok && arm_r && (op_r == `SFID_OP_RST_GO);
    end
  end

  // OTP area mode; soft reset returns to the normal array
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otp_mode_r <= `SFID_OTP_RST;
    end else if (frame_ok && op_r == `SFID_OP_OTP_IN) begin
      otp_mode_r <= 1'b1;
    end else if ((frame_ok && op_r == `SFID_OP_OTP_OUT) || soft_reset_r) begin
      otp_mode_r <= 1'b0;
    end
  end

  // Write enable latch; set wins if it meets a hardware clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_enable_latch_r <= `SFID_WEL_RST;
    end else if (frame_ok && op_r == `SFID_OP_WL_SET) begin
      write_enable_latch_r <= 1'b1;
    end else if (frame_ok && op_r == `SFID_OP_WL_CLR) begin
      write_enable_latch_r <= 1'b0;
    end else if (write_done) begin
      write_enable_latch_r <= 1'b0;
    end else if (suspend || soft_reset_r) begin
      write_enable_latch_r <= 1'b0;
    end
  end

  // Every opcode except identity read goes to the array logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_byte_r <= 8'h00;
      cmd_strobe_r <= 1'b0;
    end else begin
      cmd_strobe_r <= byte_done && (st_r == DEV_CMD) && (rx_byte != `SFID_OP_IDENT);
      if (byte_done && st_r == DEV_CMD) begin
        cmd_byte_r <= rx_byte;
      end
    end
  end

  assign link.miso_o = miso_r;
  assign link.miso_oe = miso_oe_r;
endmodule // sfid_flash_end

/* include/sfid_regs.svh */
// Opcodes, identity lengths and link timing for the flash id block.
// Assumes a single 100 MHz system clock on both ends.
`ifndef SFID_REGS_SVH
`define SFID_REGS_SVH

// Opcodes handled by the flash end
`define SFID_OP_IDENT 8'h9f
`define SFID_OP_SIG 8'hab
`define SFID_OP_MKDEV 8'h90
`define SFID_OP_OTP_IN 8'hb1
`define SFID_OP_OTP_OUT 8'hc1
`define SFID_OP_RST_ARM 8'h66
`define SFID_OP_RST_GO 8'h99
`define SFID_OP_WL_SET 8'h06
`define SFID_OP_WL_CLR 8'h04

// Last byte positions of the identity sequences, and the address that starts on the device byte
`define SFID_IDENT_LAST 2'h2
`define SFID_PRE_BYTES_LAST 2'h2
`define SFID_ADDR_DEV_FIRST 8'h01

// Bit counters
`define SFID_BIT_LAST 3'h7
`define SFID_BIT_FIRST 3'h0

// Reset values
`define SFID_WEL_RST 1'h0
`define SFID_OTP_RST 1'h0

// Link timing
`define SFID_CLK_PERIOD_NS 10
`define SFID_SCLK_PERIOD_NS 160
`define SFID_SCLK_HALF_CYC (`SFID_SCLK_PERIOD_NS / `SFID_CLK_PERIOD_NS / 2)

`endif

/* include/sfid_pkg.sv */
// Types shared by the flash end and the host end.
// Assumes sfid_regs.svh supplies the numeric constants.
package sfid_pkg;
  typedef logic [7:0] sfid_byte_type;
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_CMD, DEV_PRE, DEV_OUT, DEV_HOLD, DEV_IGNORE
  } sfid_dev_state_type;
  typedef enum logic [2:0] {
    HST_IDLE, HST_LEAD, HST_HIGH, HST_LOW, HST_TAIL, HST_GAP
  } sfid_host_state_type;
endpackage

/* include/sfid_link_if.sv */
// Serial link between host end and flash end.
// Assumes both ends run from the same system clock; the wire level of
// the serial output is resolved here, idle level high.
`timescale 1ns/1ps
interface sfid_link_if;
  logic cs_b;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Pulled high while the flash end is not driving
  assign miso = miso_oe ? miso_o : 1'b1;

  modport host (output cs_b, output sclk, output mosi, input miso);
  modport flash (input cs_b, input sclk, input mosi, output miso_o, output miso_oe);
endinterface

/* src/sfid_sync.sv */
// Two-flop synchroniser with edge pulses for link pins.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module sfid_sync #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset
  input wire logic [W-1:0] d, // Raw pin levels
  output logic [W-1:0] q, // Synchronised levels
  output logic [W-1:0] rise, // One-cycle rising pulse
  output logic [W-1:0] fall // One-cycle falling pulse
);
  logic [W-1:0] meta_r;
  logic [W-1:0] last_r;

  // Chip select and reply line idle high, so reset to ones to avoid false edges on them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '1;
      q <= '1;
      last_r <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
      last_r <= q;
    end
  end

  // Edge pulses look only at the second and third stages
  assign rise = q & ~last_r;
  assign fall = ~q & last_r;
endmodule // sfid_sync

/* src/sfid_host_end.sv */
// Host end: frames one command with optional extra bytes and reads
// back bytes. Assumes the flash end answers in serial mode 0.
`timescale 1ns/1ps
`include "sfid_regs.svh"
module sfid_host_end #(
  parameter int HALF = `SFID_SCLK_HALF_CYC // Cycles per serial clock half
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  sfid_link_if.host link, // Serial link to flash
  input wire logic start, // Pulse: begin a frame when idle
  input sfid_pkg::sfid_byte_type opcode, // Opcode to send
  input wire logic [1:0] tx_len, // Bytes after opcode, 0..3
  input wire logic [23:0] tx_data, // Those bytes, first in [23:16]
  input wire logic [1:0] rx_len, // Bytes to read back, 0..3
  output logic busy_r, // Frame in progress
  output logic done_r, // Pulse: frame finished
  output logic [23:0] rx_data_r // Last bytes read, newest in [7:0]
);
  import sfid_pkg::*;

  sfid_host_state_type st_r;
  logic [15:0] div_r;
  logic tick;
  logic [31:0] tx_r;
  logic [5:0] bits_r;
  logic [5:0] total_r;
  logic miso_q;
  logic cs_b_r;
  logic sclk_r;
  logic mosi_r;

  // Reply line is a pin, so it is synchronised first
  sfid_sync #(.W(1)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(link.miso),
    .q(miso_q),
    .rise(),
    .fall()
  );

  // Free-running half-period divider; keeps all link edges on clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 16'h0000;
    end else if (tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign tick = (div_r == 16'(HALF - 1));

  // Frame sequencer; the host never raises chip select mid-byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= HST_IDLE;
      cs_b_r <= 1'b1;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
      tx_r <= 32'h0000_0000;
      bits_r <= 6'h00;
      total_r <= 6'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rx_data_r <= 24'h00_0000;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        HST_IDLE: begin
          if (start) begin
            st_r <= HST_LEAD;
            busy_r <= 1'b1;
            tx_r <= {opcode, tx_data};
            bits_r <= 6'h00;
            total_r <= {3'h0, 3'(3'h1 + {1'b0, tx_len} + {1'b0, rx_len})} << 3;
          end
        end
        HST_LEAD: begin
          cs_b_r <= 1'b0;
          mosi_r <= tx_r[31];
          if (tick) begin
            st_r <= HST_HIGH;
          end
        end
        HST_HIGH: begin
          if (tick) begin
            sclk_r <= 1'b1;
            rx_data_r <= {rx_data_r[22:0], miso_q};
            bits_r <= bits_r + 6'h01;
            tx_r <= {tx_r[30:0], 1'b0};
            st_r <= HST_LOW;
          end
        end
        HST_LOW: begin
          if (tick) begin
            sclk_r <= 1'b0;
            mosi_r <= tx_r[31];
            st_r <= (bits_r == total_r) ? HST_TAIL : HST_HIGH;
          end
        end
        HST_TAIL: begin
          if (tick) begin
            cs_b_r <= 1'b1;
            st_r <= HST_GAP;
          end
        end
        HST_GAP: begin
          if (tick) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            st_r <= HST_IDLE;
          end
        end
        default: st_r <= HST_IDLE;
      endcase
    end
  end

  assign link.cs_b = cs_b_r;
  assign link.sclk = sclk_r;
  assign link.mosi = mosi_r;
endmodule // sfid_host_end

/* verif/sfid_link_sva.sv */
// Checker for the serial link between host end and flash end.
// Assumes it sees the link signals directly, with HALF of at least 6.
`timescale 1ns/1ps
`include "sfid_regs.svh"
module sfid_link_sva #(
  parameter logic [7:0] MAKER_ID = 8'h5a // Arbitrary value
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic cs_b, // Chip select
  input wire logic sclk, // Serial clock
  input wire logic mosi, // Host data
  input wire logic miso_o, // Flash data
  input wire logic miso_oe, // Flash drive enable
  input wire logic miso // Resolved wire
);
  logic [5:0] rise_cnt_r;
  logic [7:0] op_r;

  // Serial clock rises in the frame; saturates, frames stay short
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rise_cnt_r <= 6'h00;
    else if (cs_b) rise_cnt_r <= 6'h00;
    else if ($rose(sclk) && rise_cnt_r != 6'h3f) rise_cnt_r <= rise_cnt_r + 6'h01;
  end

  // Opcode as the host sent it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) op_r <= 8'h00;
    else if (!cs_b && $rose(sclk) && rise_cnt_r < 6'h08) op_r <= {op_r[6:0], mosi};
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_out_start_point: assert property ($rose(miso_oe) |->
    (op_r == `SFID_OP_IDENT && rise_cnt_r == 6'h08) ||
    ((op_r == `SFID_OP_MKDEV || op_r == `SFID_OP_SIG) && rise_cnt_r == 6'h20))
    else $error("flash output started at wrong bit count");
  a_first_bit_msb: assert property (
    $rose(miso_oe) && op_r == `SFID_OP_IDENT |-> miso_o == MAKER_ID[7])
    else $error("identity did not start with maker msb");
  a_out_on_fall: assert property (
    miso_oe && $past(miso_oe) && $changed(miso_o) |-> !$past(sclk))
    else $error("flash data changed while clock high");
  a_out_stable_rise: assert property ($rose(sclk) && miso_oe |-> $stable(miso_o))
    else $error("flash data moved at clock rise");
  a_release_on_cs: assert property (cs_b [*6] |-> !miso_oe)
    else $error("flash still drives after deselect");
  a_idle_line_high: assert property (!miso_oe |-> miso)
    else $error("released data wire not high");
  a_sclk_idle_low: assert property (cs_b |-> !sclk)
    else $error("serial clock high while deselected");
  a_mosi_steady_rise: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("host data moved at clock rise");
  a_whole_bytes: assert property ($rose(cs_b) |-> rise_cnt_r[2:0] == 3'h0)
    else $error("frame ended mid-byte");
  a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*6])
    else $error("serial clock high phase too short");

  // Main scenarios reached
  c_ident_out: cover property ($rose(miso_oe) && op_r == `SFID_OP_IDENT);
  c_mkdev_out: cover property ($rose(miso_oe) && op_r == `SFID_OP_MKDEV);
  c_one_byte: cover property ($rose(cs_b) && rise_cnt_r == 6'h08);
endmodule // sfid_link_sva

/* verif/sfid_tb_top.sv */
// Bench: host end and flash end joined by the link interface.
// Assumes the package, interface and opcode header are compiled first.
`timescale 1ns/1ps
`include "sfid_regs.svh"
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module spi_flash_id_and_write_latch_tb_top;
  import sfid_pkg::*;
  localparam sfid_byte_type MAKER = 8'h5a; // Arbitrary value
  localparam sfid_byte_type KIND = 8'h3c; // Arbitrary value
  localparam sfid_byte_type DEV = 8'h11; // Arbitrary value
  logic clk, rst_b, start, busy, write_done, suspend;
  sfid_byte_type opcode, cmd_byte, last_cmd;
  logic [1:0] tx_len, rx_len;
  logic [23:0] tx_data, rx_data;
  logic host_busy, done, write_enable_latch, otp, soft_rst, strobe;
  int num_errors = 0;
  int checks_done = 0;
  int resets_seen = 0;

  sfid_link_if sfid_link_if_i ();
  sfid_host_end sfid_host_end_i (.clk(clk), .rst_b(rst_b), .link(sfid_link_if_i.host),
    .start(start), .opcode(opcode), .tx_len(tx_len), .tx_data(tx_data), .rx_len(rx_len),
    .busy_r(host_busy), .done_r(done), .rx_data_r(rx_data));
  sfid_flash_end #(.MAKER_ID(MAKER), .TYPE_ID(KIND), .DEVICE_ID(DEV)) sfid_flash_end_i (
    .clk(clk), .rst_b(rst_b), .link(sfid_link_if_i.flash), .busy(busy),
    .write_done(write_done), .suspend(suspend), .write_enable_latch_r(write_enable_latch),
    .otp_mode_r(otp), .soft_reset_r(soft_rst), .cmd_byte_r(cmd_byte), .cmd_strobe_r(strobe));
  sfid_link_sva #(.MAKER_ID(MAKER)) sfid_link_sva_i (.clk(clk), .rst_b(rst_b),
    .cs_b(sfid_link_if_i.cs_b), .sclk(sfid_link_if_i.sclk), .mosi(sfid_link_if_i.mosi),
    .miso_o(sfid_link_if_i.miso_o), .miso_oe(sfid_link_if_i.miso_oe),
    .miso(sfid_link_if_i.miso));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses are caught here, so checks need not hit their one cycle
  always @(posedge clk) begin
    if (soft_rst === 1'b1) resets_seen++;
    if (strobe === 1'b1) last_cmd <= cmd_byte;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One whole frame; waits for done under a bound
  task automatic frame(input sfid_byte_type op, input logic [1:0] tl,
                       input logic [23:0] td, input logic [1:0] rl);
    int n;
    @(negedge clk);
    opcode = op;
    tx_len = tl;
    tx_data = td;
    rx_len = rl;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      stop_test();
    end
  endtask

  // Completion or suspend pulse from the array side
  task automatic hw_event(input logic is_suspend);
    @(negedge clk);
    write_done = !is_suspend;
    suspend = is_suspend;
    @(negedge clk);
    write_done = 1'b0;
    suspend = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    {start, busy, write_done, suspend} = 4'h0;
    opcode = 8'h00;
    {tx_len, rx_len, tx_data} = 28'h0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    `CHECK(write_enable_latch, 1'b0);
    `CHECK(otp, 1'b0);
    frame(`SFID_OP_IDENT, 2'h0, 24'h0, 2'h3);
    `CHECK(rx_data, {MAKER, KIND, DEV});
    `CHECK(host_busy, 1'b0);
    frame(`SFID_OP_IDENT, 2'h0, 24'h0, 2'h2);
    `CHECK(rx_data[15:0], {MAKER, KIND});
    frame(`SFID_OP_IDENT, 2'h3, 24'h0, 2'h3);
    `CHECK(rx_data, {MAKER, KIND, DEV});
    busy = 1'b1;
    frame(`SFID_OP_IDENT, 2'h0, 24'h0, 2'h3);
    `CHECK(rx_data, 24'hffffff);
    busy = 1'b0;
    frame(`SFID_OP_MKDEV, 2'h3, 24'h000000, 2'h3);
    `CHECK(rx_data, {MAKER, DEV, MAKER});
    frame(`SFID_OP_MKDEV, 2'h3, 24'h000001, 2'h3);
    `CHECK(rx_data, {DEV, MAKER, DEV});
    frame(`SFID_OP_SIG, 2'h3, 24'h0, 2'h3);
    `CHECK(rx_data, {DEV, DEV, DEV});
    // Write enable latch set and its clearing by done, suspend and clear opcode
    frame(`SFID_OP_WL_SET, 2'h0, 24'h0, 2'h0);
    `CHECK(write_enable_latch, 1'b1);
    `CHECK(last_cmd, `SFID_OP_WL_SET);
    hw_event(1'b0);
    `CHECK(write_enable_latch, 1'b0);
    frame(`SFID_OP_WL_SET, 2'h0, 24'h0, 2'h0);
    hw_event(1'b1);
    `CHECK(write_enable_latch, 1'b0);
    frame(`SFID_OP_WL_SET, 2'h0, 24'h0, 2'h0);
    frame(`SFID_OP_WL_CLR, 2'h0, 24'h0, 2'h0);
    `CHECK(write_enable_latch, 1'b0);
    frame(`SFID_OP_WL_SET, 2'h1, 24'h060000, 2'h0);
    `CHECK(write_enable_latch, 1'b0);
    frame(`SFID_OP_OTP_IN, 2'h0, 24'h0, 2'h0);
    `CHECK(otp, 1'b1);
    frame(`SFID_OP_OTP_OUT, 2'h0, 24'h0, 2'h0);
    `CHECK(otp, 1'b0);
    // Software reset, then two broken arm sequences
    frame(`SFID_OP_WL_SET, 2'h0, 24'h0, 2'h0);
    frame(`SFID_OP_RST_ARM, 2'h0, 24'h0, 2'h0);
    frame(`SFID_OP_RST_GO, 2'h0, 24'h0, 2'h0);
    `CHECK(resets_seen, 1);
    `CHECK(write_enable_latch, 1'b0);
    frame(`SFID_OP_WL_SET, 2'h0, 24'h0, 2'h0);
    frame(`SFID_OP_RST_ARM, 2'h0, 24'h0, 2'h0);
    frame(`SFID_OP_IDENT, 2'h0, 24'h0, 2'h1);
    frame(`SFID_OP_RST_GO, 2'h0, 24'h0, 2'h0);
    frame(`SFID_OP_RST_ARM, 2'h0, 24'h0, 2'h0);
    frame(8'h05, 2'h0, 24'h0, 2'h0);
    frame(`SFID_OP_RST_GO, 2'h0, 24'h0, 2'h0);
    `CHECK(resets_seen, 1);
    `CHECK(write_enable_latch, 1'b1);
    stop_test();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
endmodule // spi_flash_id_and_write_latch_tb_top
